// ---- core/cax_exec.sv ----
`timescale 1ns/100ps
// Execute stage: ALU, multiplier control and program-flow update
// Function
// RULE_01: Add source to destination, optional carry, flags ZCNVH, one clock.
// RULE_02: Subtract register or constant, optional carry, ZCNVH, one clock.
// RULE_03: Word add/subtract constant on a pair, flags ZCNVS, two clocks.
// RULE_04: AND, OR, XOR with register or constant, flags ZNV, one clock.
// RULE_05: Bit set ORs mask; bit clear ANDs 0xFF minus mask; ZNV.
// RULE_06: Zero-or-minus test ANDs destination with itself, unchanged, ZNV.
// RULE_07: Three multiplies put product in R1:R0, flags ZC, two clocks.
// RULE_08: Fractional multiplies shift product left one, R1:R0, ZC, 2 clocks.
// RULE_09: Relative jump/call load PC+k+1, no flags, two/three clocks.
// RULE_10: Indirect jump/call load PC from Z pointer, two clocks; the code gives the indirect call three clocks.
// RULE_11: Direct jump/call load absolute k, no flags, three/four clocks.
// RULE_12: Returns restore PC from stack, no flags, four clocks.
// RULE_13: Equal compare skips next instruction, no flags, 1/2/3 clocks.
// RULE_14: Compares compute difference, no store, flags ZNVCH, one clock.
// RULE_15: Bit-test skips skip when selected bit matches, 1/2/3 clocks.
// RULE_16: One's complement flags ZCNV; two's complement ZCNVH; one clock.
// RULE_17: Inc/dec/clear flags ZNV; set-register all ones, no flags.
module cax_exec
  import cax_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic req_valid,
  input wire cax_req_type req,
  input wire logic [7:0] flags_in,
  input wire logic [15:0] pc_in,
  output logic req_ready,
  output logic res_valid,
  output cax_res_type res,
  output logic [15:0] pc_out,
  output logic [2:0] cycles_out
);
  cax_state_type state_reg, state_next;
  logic [2:0] cnt_reg;
  cax_res_type res_next;
  logic [15:0] pc_next;
  logic [2:0] cyc_next;
  logic [8:0] sum9;
  logic [16:0] w17;
  logic [7:0] r8;
  logic cin, is_sub, arith, skip, is_mul, m_as, m_bs, m_fr;
  logic [15:0] m_prod;
  logic m_carry;
  logic [7:0] opb;

  cax_mult u_mult (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .start(req_valid && req_ready && is_mul),
    .a_signed(m_as),
    .b_signed(m_bs),
    .frac(m_fr),
    .a(req.dst),
    .b(req.src_reg),
    .prod(m_prod),
    .carry(m_carry)
  );
  // Multiplier mode decode
  always_comb begin
    m_as = req.op inside {OP_SMUL, OP_MMUL, OP_FSMUL, OP_FMMUL};
    m_bs = req.op inside {OP_SMUL, OP_FSMUL};
    m_fr = req.op inside {OP_FUMUL, OP_FSMUL, OP_FMMUL};
    is_mul = m_fr || req.op inside {OP_UMUL, OP_SMUL, OP_MMUL};
  end
  // Byte ALU: adder/subtractor shared by arithmetic and compares
  always_comb begin
    is_sub = req.op inside {OP_SUB, OP_DIFF_CONST, OP_DIFF_BORROW,
      OP_CONST_DIFF_BORROW, OP_DIFF_CHECK, OP_BORROW_DIFF_CHECK,
      OP_CONST_DIFF_CHECK, OP_TWOS_INVERT, OP_DEC};
    cin = req.op inside {OP_ADC, OP_DIFF_BORROW, OP_CONST_DIFF_BORROW,
      OP_BORROW_DIFF_CHECK} ? flags_in[FL_C] : 1'b0;
    opb = req.src_reg;
    if (req.op inside {OP_DIFF_CONST, OP_CONST_DIFF_BORROW,
        OP_CONST_DIFF_CHECK}) begin
      opb = req.imm;
    end else if (req.op inside {OP_INC, OP_DEC}) begin
      opb = 8'h01;
    end
    if (req.op == OP_TWOS_INVERT) begin
      sum9 = {1'b0, ZERO_BYTE} - {1'b0, req.dst}; // see RULE_16
    end else if (is_sub) begin
      sum9 = {1'b0, req.dst} - {1'b0, opb} - {8'h00, cin}; // see RULE_02
    end else begin
      sum9 = {1'b0, req.dst} + {1'b0, opb} + {8'h00, cin}; // see RULE_01
    end
    // Word arithmetic on the high:low pair
    if (req.op == OP_WORD_DIFF) begin
      w17 = {1'b0, req.dst_hi, req.dst} - {9'h000, req.imm}; // see RULE_03
    end else begin
      w17 = {1'b0, req.dst_hi, req.dst} + {9'h000, req.imm}; // see RULE_03
    end
  end
  // Result, flag and next-PC selection
  always_comb begin
    res_next = '0;
    pc_next = pc_in + 16'h0001;
    cyc_next = CYC_ONE;
    skip = 1'b0;
    r8 = sum9[7:0];
    arith = 1'b0;
    case (req.op)
      OP_ADD, OP_ADC, OP_SUB, OP_DIFF_CONST, OP_DIFF_BORROW,
      OP_CONST_DIFF_BORROW, OP_TWOS_INVERT: begin
        arith = 1'b1;
        res_next.wr_dst = 1'b1;
      end
      OP_DIFF_CHECK, OP_BORROW_DIFF_CHECK, OP_CONST_DIFF_CHECK: begin
        arith = 1'b1; // see RULE_14
      end
      OP_AND, OP_ZERO_SIGN_CHECK: r8 = req.dst & // see RULE_06
        (req.op == OP_AND ? req.src_reg : req.dst); // see RULE_04
      OP_MASK_CONST: r8 = req.dst & req.imm; // see RULE_04
      OP_OR: r8 = req.dst | req.src_reg; // see RULE_04
      OP_MERGE_CONST, OP_BIT_SET_MASK: r8 = req.dst | req.imm; // see RULE_05
      OP_BIT_CLEAR_MASK: r8 = req.dst & (ALL_ONES - req.imm); // see RULE_05
      OP_EXCL_MERGE: r8 = req.dst ^ req.src_reg; // see RULE_04
      OP_ZERO_FILL: r8 = req.dst ^ req.dst; // see RULE_17
      OP_ONES_INVERT: r8 = ALL_ONES - req.dst; // see RULE_16
      OP_INC, OP_DEC: r8 = sum9[7:0]; // see RULE_17
      OP_ONES_FILL: r8 = ALL_ONES; // see RULE_17
      OP_WORD_SUM, OP_WORD_DIFF: cyc_next = CYC_TWO; // see RULE_03
      OP_UMUL, OP_SMUL, OP_MMUL, OP_FUMUL, OP_FSMUL, OP_FMMUL:
        cyc_next = CYC_TWO; // see RULE_07
      OP_REL_BRANCH, OP_REL_INVOKE: begin
        pc_next = pc_in + req.target + 16'h0001; // see RULE_09
        cyc_next = (req.op == OP_REL_BRANCH) ? CYC_TWO : CYC_THREE;
      end
      OP_PTR_BRANCH, OP_PTR_INVOKE: begin
        pc_next = req.zptr; // see RULE_10
        cyc_next = (req.op == OP_PTR_BRANCH) ? CYC_TWO : CYC_THREE;
      end
      OP_ABS_BRANCH, OP_ABS_INVOKE: begin
        pc_next = req.target; // see RULE_11
        cyc_next = (req.op == OP_ABS_BRANCH) ? CYC_THREE : CYC_FOUR;
      end
      OP_SUB_EXIT, OP_HANDLER_EXIT: begin
        pc_next = req.stack_pc; // see RULE_12
        cyc_next = CYC_FOUR;
      end
      OP_EQUAL_SKIP: skip = (req.dst == req.src_reg); // see RULE_13
      OP_SKIP_BIT_LOW: skip = ~req.src_reg[req.bit_sel]; // see RULE_15
      OP_SKIP_BIT_HIGH: skip = req.src_reg[req.bit_sel]; // see RULE_15
      default: ;
    endcase
    // Skip length depends on the size of the skipped instruction
    if (skip) begin
      pc_next = pc_in + (req.next_two_words ? 16'h0003 : 16'h0002);
      cyc_next = req.next_two_words ? CYC_THREE : CYC_TWO;
    end
    res_next.data = {8'h00, r8};
    res_next.flags[FL_Z] = (r8 == ZERO_BYTE);
    res_next.flags[FL_N] = r8[7];
    if (req.op inside {OP_AND, OP_MASK_CONST, OP_OR, OP_MERGE_CONST,
        OP_EXCL_MERGE, OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK,
        OP_ZERO_SIGN_CHECK, OP_ZERO_FILL, OP_INC, OP_DEC}) begin
      res_next.wr_dst = (req.op != OP_ZERO_SIGN_CHECK);
      res_next.flag_mask = 8'h0e; // Z,N,V; V cleared for logic ops
      if (req.op == OP_INC) begin
        res_next.flags[FL_V] = (req.dst == 8'h7f);
      end else if (req.op == OP_DEC) begin
        res_next.flags[FL_V] = (req.dst == 8'h80);
      end
    end
    if (req.op == OP_ONES_INVERT) begin
      res_next.wr_dst = 1'b1;
      res_next.flags[FL_C] = 1'b1; // Complement always sets carry
      res_next.flag_mask = 8'h0f;
    end
    if (req.op == OP_ONES_FILL) begin
      res_next.wr_dst = 1'b1;
    end
    if (arith) begin
      res_next.flags[FL_C] = sum9[8];
      res_next.flags[FL_V] = is_sub ?
        ((req.dst[7] ^ opb[7]) & (req.dst[7] ^ r8[7])) :
        (~(req.dst[7] ^ opb[7]) & (req.dst[7] ^ r8[7]));
      if (req.op == OP_TWOS_INVERT) begin
        res_next.flags[FL_V] = (r8 == 8'h80);
        res_next.flags[FL_H] = r8[3] | req.dst[3];
      end else begin
        res_next.flags[FL_H] = is_sub ?
          ((~req.dst[3] & opb[3]) | (opb[3] & r8[3]) | (r8[3] & ~req.dst[3])) :
          ((req.dst[3] & opb[3]) | (opb[3] & ~r8[3]) | (~r8[3] & req.dst[3]));
      end
      // Carry-chained subtract and compare keep Z clear unless already set
      if (req.op inside {OP_DIFF_BORROW, OP_CONST_DIFF_BORROW,
          OP_BORROW_DIFF_CHECK}) begin
        res_next.flags[FL_Z] = (r8 == ZERO_BYTE) & flags_in[FL_Z];
      end
      res_next.flag_mask = 8'h2f;
    end
    if (req.op inside {OP_WORD_SUM, OP_WORD_DIFF}) begin
      res_next.wr_pair = 1'b1;
      res_next.data = w17[15:0];
      res_next.flags[FL_Z] = (w17[15:0] == 16'h0000);
      res_next.flags[FL_N] = w17[15];
      res_next.flags[FL_C] = w17[16];
      res_next.flags[FL_V] = (req.op == OP_WORD_SUM) ?
        (~req.dst_hi[7] & w17[15]) : (req.dst_hi[7] & ~w17[15]);
      res_next.flags[FL_S] = res_next.flags[FL_N] ^ res_next.flags[FL_V];
      res_next.flag_mask = 8'h1f;
    end
    if (is_mul) begin
      res_next.wr_r1r0 = 1'b1; // see RULE_08
      res_next.flag_mask = 8'h03;
    end
  end
  // Controller: one-cycle ops answer at once, others hold the engine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (req_valid && cyc_next != CYC_ONE) state_next = ST_WAIT;
      ST_WAIT: if (cnt_reg == CYC_ONE) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end
  assign req_ready = (state_reg == ST_IDLE);
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
    end else if (ce) begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && req_valid) begin
        cnt_reg <= cyc_next - CYC_ONE;
      end else if (cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - CYC_ONE;
      end
    end
  end
  // Result register; multiply data patched when product is ready
  always_ff @(posedge clk) begin
    if (srst) begin
      res_valid <= 1'b0;
      res <= '0;
      pc_out <= PC_RESET;
      cycles_out <= 3'h0;
    end else if (ce) begin
      res_valid <= 1'b0;
      if (req_valid && req_ready) begin
        res <= res_next;
        pc_out <= pc_next;
        cycles_out <= cyc_next;
        res_valid <= (cyc_next == CYC_ONE);
      end else if (state_reg == ST_WAIT && cnt_reg == CYC_ONE) begin
        res_valid <= 1'b1;
        if (res.wr_r1r0) begin
          res.data <= m_prod;
          res.flags[FL_Z] <= (m_prod == 16'h0000);
          res.flags[FL_C] <= m_carry;
        end
      end
    end
  end

  // Checks
  mul_cyc_a: assert property (@(posedge clk) disable iff (srst) // see RULE_07
    (ce && req_valid && req_ready && is_mul) ##1 ce |=> res_valid)
    else $error("multiply answer late");
  one_cyc_a: assert property (@(posedge clk) disable iff (srst) // see RULE_01
    (ce && req_valid && req_ready && req.op == OP_ADD) |=> res_valid)
    else $error("add answer late");
  add_val_a: assert property (@(posedge clk) disable iff (srst) // see RULE_01
    (ce && req_valid && req_ready && req.op == OP_ADD) |=>
    res.data[7:0] == $past(req.dst) + $past(req.src_reg))
    else $error("add result wrong");
  cmp_nowr_a: assert property (@(posedge clk) disable iff (srst) // see RULE_14
    (ce && req_ready && req.op == OP_DIFF_CHECK && req_valid) |=> !res.wr_dst)
    else $error("compare wrote destination");
  jmp_pc_a: assert property (@(posedge clk) disable iff (srst) // see RULE_11
    (ce && req_valid && req_ready && req.op == OP_ABS_BRANCH) |=>
    pc_out == $past(req.target) && cycles_out == CYC_THREE)
    else $error("direct jump wrong");
  ret_cyc_a: assert property (@(posedge clk) disable iff (srst) // see RULE_12
    (ce && req_valid && req_ready && req.op == OP_SUB_EXIT) |=>
    cycles_out == CYC_FOUR && res.flag_mask == 8'h00)
    else $error("return wrong");
  relative_branch_always_pc_a: assert property (@(posedge clk) disable iff (srst) // see RULE_09
    (ce && req_valid && req_ready && req.op == OP_REL_BRANCH) |=>
    pc_out == $past(pc_in) + $past(req.target) + 16'h0001)
    else $error("relative jump wrong");
  skip_pc_a: assert property (@(posedge clk) disable iff (srst) // see RULE_13
    (ce && req_valid && req_ready && req.op == OP_EQUAL_SKIP &&
    req.dst == req.src_reg && !req.next_two_words) |=>
    pc_out == $past(pc_in) + 16'h0002)
    else $error("equal skip wrong");
  cov_mul_c: cover property (@(posedge clk) req_valid && is_mul);
  cov_skip_c: cover property (@(posedge clk) req_valid && skip);
  cov_call_c: cover property (@(posedge clk)
    req_valid && req.op == OP_ABS_INVOKE);
endmodule // cax_exec

// ---- core/cax_pkg.sv ----
// Shared constants and types for the execute datapath
package cax_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // Cycle counts per instruction class
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  // Status bit positions in the flag byte
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  typedef enum logic [5:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_DIFF_CONST, OP_DIFF_BORROW,
    OP_CONST_DIFF_BORROW, OP_AND, OP_MASK_CONST, OP_OR, OP_MERGE_CONST,
    OP_EXCL_MERGE, OP_ONES_INVERT, OP_TWOS_INVERT, OP_BIT_SET_MASK,
    OP_BIT_CLEAR_MASK, OP_INC, OP_DEC, OP_ZERO_SIGN_CHECK, OP_ZERO_FILL,
    OP_ONES_FILL, OP_WORD_SUM, OP_WORD_DIFF, OP_UMUL, OP_SMUL, OP_MMUL,
    OP_FUMUL, OP_FSMUL, OP_FMMUL, OP_REL_BRANCH, OP_PTR_BRANCH,
    OP_ABS_BRANCH, OP_REL_INVOKE, OP_PTR_INVOKE, OP_ABS_INVOKE,
    OP_SUB_EXIT, OP_HANDLER_EXIT, OP_EQUAL_SKIP, OP_DIFF_CHECK,
    OP_BORROW_DIFF_CHECK, OP_CONST_DIFF_CHECK, OP_SKIP_BIT_LOW,
    OP_SKIP_BIT_HIGH
  } cax_op_type;

  // One-hot controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } cax_state_type;

  typedef struct packed {
    cax_op_type op;
    logic [7:0] dst;
    logic [7:0] dst_hi;
    logic [7:0] src_reg;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [15:0] target;
    logic [15:0] zptr;
    logic [15:0] stack_pc;
    logic next_two_words;
  } cax_req_type;

  typedef struct packed {
    logic wr_dst;
    logic wr_pair;
    logic wr_r1r0;
    logic [15:0] data;
    logic [7:0] flags;
    logic [7:0] flag_mask;
  } cax_res_type;
endpackage

// ---- core/cax_mult.sv ----
`timescale 1ns/100ps
// Registered 8x8 multiplier with signedness and fractional shift
module cax_mult
  import cax_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  input wire logic a_signed,
  input wire logic b_signed,
  input wire logic frac,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [15:0] prod,
  output logic carry
);
  logic signed [17:0] full;
  logic [15:0] raw;

  // Sign-extend each operand per mode, then multiply
  always_comb begin
    full = $signed({a_signed & a[7], a_signed & a[7], a}) *
           $signed({b_signed & b[7], b_signed & b[7], b});
    raw = full[15:0];
  end

  // Carry is product bit 15 before the fractional shift
  always_ff @(posedge clk) begin
    if (srst) begin
      prod <= 16'h0000;
      carry <= 1'b0;
    end else if (ce && start) begin
      prod <= frac ? {raw[14:0], 1'b0} : raw;
      carry <= raw[15];
    end
  end
endmodule // cax_mult

// ---- verif/cax_exec_tb.sv ----
// Self-checking bench for the execute stage against a reference model
`timescale 1ns/100ps
module cax_exec_tb;
  import cax_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  cax_req_type req = '0;
  logic [7:0] flags_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic req_ready;
  logic res_valid;
  cax_res_type res;
  logic [15:0] pc_out;
  logic [2:0] cycles_out;
  int bad_count = 0;
  int compares = 0;
  cax_op_type op_r;
  logic [7:0] im_r;
  logic [15:0] pc_r;

  // 20 MHz core clock
  always #25 clk = ~clk;

  cax_exec u_cax_exec (.clk(clk), .srst(srst), .ce(ce),
    .req_valid(req_valid), .req(req), .flags_in(flags_in), .pc_in(pc_in),
    .req_ready(req_ready), .res_valid(res_valid), .res(res),
    .pc_out(pc_out), .cycles_out(cycles_out));

  // Case inequality so an unknown never passes
  task automatic check_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Model one instruction, issue it, wait for the answer, compare all
  task automatic run_op(input cax_op_type op, input logic [7:0] d, dh, s,
                        input logic [7:0] im, input logic [2:0] b,
                        input logic [15:0] t = 16'h0000,
                        input logic nw = 1'b0);
    int a, o, ci, x, y, n, k;
    logic [7:0] r8, ef, em;
    logic [15:0] r16, epc, w, zp, sp;
    logic [2:0] wr;
    logic chain;
    zp = 16'($urandom);
    sp = 16'($urandom);
    flags_in = 8'($urandom);
    pc_in = 16'($urandom);
    a = d;
    o = (op inside {OP_DIFF_CONST, OP_CONST_DIFF_BORROW, OP_CONST_DIFF_CHECK,
         OP_MASK_CONST, OP_MERGE_CONST, OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK})
        ? int'(im) : int'(s);
    chain = op inside {OP_ADC, OP_DIFF_BORROW, OP_CONST_DIFF_BORROW,
                       OP_BORROW_DIFF_CHECK};
    ci = chain ? int'(flags_in[FL_C]) : 0;
    chain = chain && op != OP_ADC;
    r8 = d;
    r16 = 16'h0000;
    ef = 8'h00;
    em = 8'h0e;
    wr = 3'b100;
    epc = pc_in + 16'h0001;
    n = 1;
    case (op)
      OP_ADD, OP_ADC: begin
        x = a + o + ci;
        r8 = x[7:0];
        em = 8'h2f;
        ef[FL_C] = x > 255;
        ef[FL_H] = (a % 16) + (o % 16) + ci > 15;
        ef[FL_V] = (a[7] == o[7]) && (r8[7] != a[7]);
      end
      OP_SUB, OP_DIFF_CONST, OP_DIFF_BORROW, OP_CONST_DIFF_BORROW,
      OP_DIFF_CHECK, OP_BORROW_DIFF_CHECK, OP_CONST_DIFF_CHECK,
      OP_TWOS_INVERT: begin
        // Negation is zero minus the register
        if (op == OP_TWOS_INVERT) begin
          o = a;
          a = 0;
        end
        x = a - o - ci;
        r8 = x[7:0];
        em = 8'h2f;
        ef[FL_C] = x < 0;
        ef[FL_H] = (a % 16) - (o % 16) - ci < 0;
        ef[FL_V] = (a[7] != o[7]) && (r8[7] != a[7]);
        if (op inside {OP_DIFF_CHECK, OP_BORROW_DIFF_CHECK,
                       OP_CONST_DIFF_CHECK}) begin
          wr = 3'b000;
        end
      end
      OP_AND, OP_MASK_CONST: r8 = d & o[7:0];
      OP_OR, OP_MERGE_CONST, OP_BIT_SET_MASK: r8 = d | o[7:0];
      OP_EXCL_MERGE: r8 = d ^ o[7:0];
      OP_BIT_CLEAR_MASK: r8 = d & (8'hff - o[7:0]);
      OP_ZERO_FILL: r8 = 8'h00;
      OP_ZERO_SIGN_CHECK: wr = 3'b000;
      OP_INC: begin
        r8 = d + 8'h01;
        ef[FL_V] = r8 == 8'h80;
      end
      OP_DEC: begin
        r8 = d - 8'h01;
        ef[FL_V] = r8 == 8'h7f;
      end
      OP_ONES_INVERT: begin
        r8 = 8'hff - d;
        em = 8'h0f;
        ef[FL_C] = 1'b1;
      end
      OP_ONES_FILL: begin
        r8 = 8'hff;
        em = 8'h00;
      end
      OP_WORD_SUM, OP_WORD_DIFF: begin
        w = {dh, d};
        r16 = (op == OP_WORD_SUM) ? w + {8'h00, im} : w - {8'h00, im};
        em = 8'h1f;
        wr = 3'b010;
        n = 2;
        ef[FL_V] = (op == OP_WORD_SUM) ? !dh[7] && r16[15] : dh[7] && !r16[15];
        ef[FL_C] = (op == OP_WORD_SUM) ? dh[7] && !r16[15] : !dh[7] && r16[15];
        ef[FL_N] = r16[15];
        ef[FL_Z] = r16 == 16'h0000;
        ef[FL_S] = ef[FL_N] ^ ef[FL_V];
      end
      OP_UMUL, OP_SMUL, OP_MMUL, OP_FUMUL, OP_FSMUL, OP_FMMUL: begin
        // Carry is taken before the fractional shift
        x = (op inside {OP_UMUL, OP_FUMUL}) ? a : int'($signed(d));
        y = (op inside {OP_SMUL, OP_FSMUL}) ? int'($signed(s)) : int'(s);
        w = 16'(x * y);
        ef[FL_C] = w[15];
        r16 = (op inside {OP_FUMUL, OP_FSMUL, OP_FMMUL}) ? w << 1 : w;
        ef[FL_Z] = r16 == 16'h0000;
        em = 8'h03;
        wr = 3'b001;
        n = 2;
      end
      default: begin
        // Program-flow group writes nothing and touches no flag
        wr = 3'b000;
        em = 8'h00;
        case (op)
          OP_REL_BRANCH, OP_REL_INVOKE: epc = pc_in + t + 16'h0001;
          OP_PTR_BRANCH, OP_PTR_INVOKE: epc = zp;
          OP_ABS_BRANCH, OP_ABS_INVOKE: epc = t;
          OP_SUB_EXIT, OP_HANDLER_EXIT: epc = sp;
          default: begin
            if (op == OP_EQUAL_SKIP ? d == s :
                s[b] == (op == OP_SKIP_BIT_HIGH)) n = nw ? 3 : 2;
            epc = pc_in + 16'(n);
          end
        endcase
        if (op inside {OP_REL_BRANCH, OP_PTR_BRANCH}) n = 2;
        if (op inside {OP_REL_INVOKE, OP_PTR_INVOKE, OP_ABS_BRANCH}) n = 3;
        if (op inside {OP_ABS_INVOKE, OP_SUB_EXIT, OP_HANDLER_EXIT}) n = 4;
      end
    endcase
    if (em[FL_N] && wr != 3'b010) begin
      ef[FL_N] = r8[7];
      ef[FL_Z] = r8 == 8'h00 && (!chain || flags_in[FL_Z]);
    end
    req = '{op: op, dst: d, dst_hi: dh, src_reg: s, imm: im, bit_sel: b,
            target: t, zptr: zp, stack_pc: sp, next_two_words: nw};
    req_valid = 1'b1;
    check_val("ready idle", 16'h0001, {15'h0, req_ready});
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    // Multicycle work must refuse new requests
    if (n > 1) check_val("ready busy", 16'h0000, {15'h0, req_ready});
    // The accept edge already counts as the first clock
    k = 1;
    while (res_valid !== 1'b1 && k < 12) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (res_valid !== 1'b1) begin
      bad_count++;
      $display("[FAIL] result wait expected 1 seen 0");
      give_verdict();
    end
    check_val("latency", 16'(n), 16'(k));
    check_val("cycles", 16'(n), {13'h0, cycles_out});
    check_val("pc", epc, pc_out);
    check_val("flag mask", {8'h00, em}, {8'h00, res.flag_mask});
    check_val("flags", {8'h00, ef & em}, {8'h00, res.flags & em});
    check_val("writes", {13'h0, wr},
              {13'h0, res.wr_dst, res.wr_pair, res.wr_r1r0});
    if (wr[2] || op == OP_ZERO_SIGN_CHECK)
      check_val("byte", {8'h00, r8}, {8'h00, res.data[7:0]});
    if (wr[1:0] != 2'b00) check_val("word", r16, res.data);
  endtask

  // Reset, directed corners, then every operation with random operands
  initial begin
    void'($urandom(32'hbb9d));
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    check_val("reset valid", 16'h0000, {15'h0, res_valid});
    check_val("reset pc", PC_RESET, pc_out);
    run_op(OP_ADD, 8'h80, 8'h0, 8'h80, 8'h0, 3'h0);
    run_op(OP_ADC, 8'hff, 8'h0, 8'h0, 8'h0, 3'h0);
    run_op(OP_DIFF_BORROW, 8'h05, 8'h0, 8'h05, 8'h0, 3'h0);
    run_op(OP_DIFF_CONST, 8'h10, 8'h0, 8'h0, 8'h01, 3'h0);
    run_op(OP_WORD_SUM, 8'hff, 8'h7f, 8'h0, 8'h01, 3'h0);
    run_op(OP_WORD_DIFF, 8'h0, 8'h0, 8'h0, 8'h01, 3'h0);
    run_op(OP_EXCL_MERGE, 8'h5a, 8'h0, 8'h5a, 8'h0, 3'h0);
    run_op(OP_BIT_CLEAR_MASK, 8'hff, 8'h0, 8'h0, 8'h0f, 3'h0);
    run_op(OP_ZERO_SIGN_CHECK, 8'h80, 8'h0, 8'h0, 8'h0, 3'h0);
    run_op(OP_SMUL, 8'h80, 8'h0, 8'h80, 8'h0, 3'h0);
    run_op(OP_FUMUL, 8'hff, 8'h0, 8'hff, 8'h0, 3'h0);
    run_op(OP_FSMUL, 8'h80, 8'h0, 8'h80, 8'h0, 3'h0);
    run_op(OP_REL_INVOKE, 8'h0, 8'h0, 8'h0, 8'h0, 3'h0,
           16'hffff);
    run_op(OP_PTR_INVOKE, 8'h0, 8'h0, 8'h0, 8'h0, 3'h0);
    run_op(OP_ABS_INVOKE, 8'h0, 8'h0, 8'h0, 8'h0, 3'h0,
           16'h1234);
    run_op(OP_HANDLER_EXIT, 8'h0, 8'h0, 8'h0, 8'h0, 3'h0);
    run_op(OP_EQUAL_SKIP, 8'h33, 8'h0, 8'h33, 8'h0, 3'h0, 16'h0,
           1'b1);
    run_op(OP_DIFF_CHECK, 8'h40, 8'h0, 8'h41, 8'h0, 3'h0);
    run_op(OP_SKIP_BIT_HIGH, 8'h0, 8'h0, 8'h80, 8'h0, 3'h7);
    run_op(OP_TWOS_INVERT, 8'h80, 8'h0, 8'h0, 8'h0, 3'h0);
    run_op(OP_INC, 8'h7f, 8'h0, 8'h0, 8'h0, 3'h0);
    // Enable low must freeze everything, even with a request raised
    pc_r = pc_out;
    ce = 1'b0;
    req.op = OP_ABS_INVOKE;
    req.target = ~pc_r;
    req_valid = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_val("frozen pc", pc_r, pc_out);
    check_val("frozen ready", 16'h0001, {15'h0, req_ready});
    ce = 1'b1;
    req_valid = 1'b0;
    @(posedge clk);
    #1;
    op_r = op_r.first();
    repeat (op_r.num()) begin
      repeat (8) begin
        im_r = 8'($urandom);
        if (op_r inside {OP_WORD_SUM, OP_WORD_DIFF}) im_r = im_r & 8'h3f;
        run_op(op_r, 8'($urandom), 8'($urandom), 8'($urandom), im_r,
               3'($urandom), 16'($urandom), 1'($urandom));
      end
      op_r = op_r.next();
    end
    give_verdict();
  end
endmodule // cax_exec_tb
